// ==== rtl/agcr_regs.sv ====
// Purpose: APB register bank for channel gains and chop/detect setup
// Assumes: Single clock pclk at 50 MHz, presetn asynchronous active low
// Notes:   Zero wait states; unmapped addresses read zero and answer pslverr
`timescale 1ns/1ps
//
// Contract
// - Each gain code is 3 bits, gain is two to the code, reset 000b.
// - Lower gain register holds channel 1 at 6:4, channel 0 at 2:0.
// - Upper gain register holds channel 5 at 6:4, channel 4 at 2:0.
// - Upper gain register sits at index 5h and resets to 0000h.
// - Configuration register sits at index 06h and resets to 0600h.
// - Chop delay code n at 12:9 waits two to n+1 modulator clocks.
// - Bit 8 enables global chop, reset cleared.
// - Bit 7 selects all-channel trigger when set, any channel when clear.
// - Bits 6:4 give exceed count two to the code.
// - Bits 3:1 give detection length, code 000b meaning 128 periods.
module agcr_regs
   import agcr_pkg::*;
(
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [13:0]          paddr,
   input  wire logic [31:0]          pwdata,
   input  wire logic [3:0]           pstrb,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   output agcr_pkg::agcr_gain_t      ch0_gain_code,
   output agcr_pkg::agcr_gain_t      ch1_gain_code,
   output agcr_pkg::agcr_gain_t      ch4_gain_code,
   output agcr_pkg::agcr_gain_t      ch5_gain_code,
   output logic      [7:0]           ch0_gain_mult,
   output logic      [7:0]           ch1_gain_mult,
   output logic      [7:0]           ch4_gain_mult,
   output logic      [7:0]           ch5_gain_mult,
   output logic      [3:0]           chop_settle_delay,
   output logic      [16:0]          chop_settle_cycles,
   output logic                      chop_enable,
   output logic                      detect_all_channels,
   output logic      [2:0]           detect_exceed_count,
   output logic      [7:0]           detect_exceed_needed,
   output logic      [2:0]           detect_window_length,
   output logic      [3:0]           detect_window_log2,
   output logic                      detect_enable
);
   import agcr_pkg::*;

   logic [15:0] low_gain_q;
   logic [15:0] low_gain_d;
   logic [15:0] up_gain_q;
   logic [15:0] up_gain_d;
   logic [15:0] cfg_q;
   logic [15:0] cfg_d;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic        err_q;
   logic        err_d;
   logic [11:0] idx;
   logic        setup;
   logic        hit_low;
   logic        hit_up;
   logic        hit_cfg;
   logic        mapped;
   logic [15:0] wmask;
   agcr_gain_t  gain_code [4];
   logic [7:0]  gain_mult [4];
   genvar       g;

   assign idx   = paddr[13:2];
   assign setup = psel && !penable;
   assign wmask = {{8{pstrb[1]}}, {8{pstrb[0]}}};

   always_comb begin
      hit_low = 1'b0;
      hit_up  = 1'b0;
      hit_cfg = 1'b0;
      if (idx == AGCR_IDX_LOW_GAIN) begin
         hit_low = 1'b1;
      end else if (idx == AGCR_IDX_UP_GAIN) begin
         hit_up = 1'b1;
      end else if (idx == AGCR_IDX_CFG) begin
         hit_cfg = 1'b1;
      end
   end
   assign mapped = hit_low || hit_up || hit_cfg;

   // Writes take effect in the access phase; bytes enabled by pstrb[1:0] stored, reserved too
   always_comb begin
      low_gain_d = low_gain_q;
      up_gain_d  = up_gain_q;
      cfg_d      = cfg_q;
      if (psel && penable && pwrite) begin
         if (hit_low) begin
            low_gain_d = (low_gain_q & ~wmask) | (pwdata[15:0] & wmask);
         end else if (hit_up) begin
            up_gain_d = (up_gain_q & ~wmask) | (pwdata[15:0] & wmask);
         end else if (hit_cfg) begin
            cfg_d = (cfg_q & ~wmask) | (pwdata[15:0] & wmask);
         end
      end
   end

   // Read data captured at setup of a read, cleared after its access
   always_comb begin
      rdata_d = 32'h0000_0000;
      err_d   = 1'b0;
      if (setup) begin
         err_d = !mapped;
         if (!pwrite) begin
            if (hit_low) begin
               rdata_d = {16'h0000, low_gain_q};
            end else if (hit_up) begin
               rdata_d = {16'h0000, up_gain_q};
            end else if (hit_cfg) begin
               rdata_d = {16'h0000, cfg_q};
            end
         end
      end
   end

   // Register state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low_gain_q <= AGCR_RST_LOW_GAIN;
         up_gain_q  <= AGCR_RST_UP_GAIN;
         cfg_q      <= AGCR_RST_CFG;
      end else begin
         low_gain_q <= low_gain_d;
         up_gain_q  <= up_gain_d;
         cfg_q      <= cfg_d;
      end
   end

   // Read capture state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_q <= 32'h0000_0000;
         err_q   <= 1'b0;
      end else begin
         rdata_q <= rdata_d;
         err_q   <= err_d;
      end
   end

   assign pready  = 1'b1;
   assign prdata  = rdata_q;
   assign pslverr = psel && penable && err_q;

   // Field extraction
   assign ch0_gain_code = low_gain_q[AGCR_LO_GAIN_LSB +: 3];
   assign ch1_gain_code = low_gain_q[AGCR_HI_GAIN_LSB +: 3];
   assign ch4_gain_code = up_gain_q[AGCR_LO_GAIN_LSB +: 3];
   assign ch5_gain_code = up_gain_q[AGCR_HI_GAIN_LSB +: 3];

   // Gain multiplier per channel, two to the code
   assign gain_code[0] = ch0_gain_code;
   assign gain_code[1] = ch1_gain_code;
   assign gain_code[2] = ch4_gain_code;
   assign gain_code[3] = ch5_gain_code;
   for (g = 0; g < 4; g = g + 1) begin : g_mult
      assign gain_mult[g] = 8'h01 << gain_code[g];
      gain_pow2_a: assert property (@(posedge pclk) disable iff (!presetn)
         $onehot(gain_mult[g]) && gain_mult[g][gain_code[g]])
         else $error("Gain multiplier not a power of two");
   end
   assign ch0_gain_mult = gain_mult[0];
   assign ch1_gain_mult = gain_mult[1];
   assign ch4_gain_mult = gain_mult[2];
   assign ch5_gain_mult = gain_mult[3];

   assign chop_settle_delay  = cfg_q[AGCR_DLY_LSB +: 4];
   assign chop_settle_cycles = 17'h00002 << chop_settle_delay;
   assign chop_enable        = cfg_q[AGCR_CHOP_EN_BIT];
   assign detect_all_channels = cfg_q[AGCR_ALLCH_BIT];
   assign detect_exceed_count = cfg_q[AGCR_NUM_LSB +: 3];
   assign detect_exceed_needed = 8'h01 << detect_exceed_count;
   assign detect_window_length = cfg_q[AGCR_LEN_LSB +: 3];
   assign detect_window_log2 = {1'b0, detect_window_length} +
                               {1'b0, AGCR_LEN_BASE_LOG2};
   assign detect_enable = cfg_q[AGCR_DET_EN_BIT];

   // Checks
   property reset_vals_p;
      @(posedge pclk) $rose(presetn) |->
         (up_gain_q == 16'h0000) && (cfg_q == 16'h0600) && (low_gain_q == 16'h0000);
   endproperty
   reset_vals_a: assert property (reset_vals_p)
      else $error("Register reset value wrong");

   sequence wr_cfg_s;
      psel && penable && pwrite && hit_cfg && (pstrb == 4'hf);
   endsequence
   cfg_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr_cfg_s |=> cfg_q == $past(pwdata[15:0]))
      else $error("Configuration write lost");

   sequence wr_up_s;
      psel && penable && pwrite && hit_up && (pstrb == 4'hf);
   endsequence
   up_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr_up_s |=> (ch5_gain_code == $past(pwdata[6:4])) &&
                  (ch4_gain_code == $past(pwdata[2:0])))
      else $error("Upper gain fields misplaced");

   low_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable && pwrite && hit_low && pstrb[0]) |=>
         (ch1_gain_code == $past(pwdata[6:4])) && (ch0_gain_code == $past(pwdata[2:0])))
      else $error("Lower gain fields misplaced");

   gain_mult_a: assert property (@(posedge pclk) disable iff (!presetn)
      (ch0_gain_code == 3'h7) |-> (ch0_gain_mult == 8'h80))
      else $error("Gain code 7 not 128");

   chop_delay_a: assert property (@(posedge pclk) disable iff (!presetn)
      (chop_settle_delay == 4'hf) |-> (chop_settle_cycles == 17'h10000))
      else $error("Chop delay code 15 not 65536");

   chop_en_a: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_cfg_s ##1 1'b1) |-> (chop_enable == $past(pwdata[8])))
      else $error("Chop enable not at bit 8");

   allch_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr_cfg_s |=> (detect_all_channels == $past(pwdata[7])))
      else $error("All-channel select not at bit 7");

   exceed_cnt_a: assert property (@(posedge pclk) disable iff (!presetn)
      (detect_exceed_count == 3'h0) |-> (detect_exceed_needed == 8'h01))
      else $error("Exceed count code 0 not 1");

   win_len_a: assert property (@(posedge pclk) disable iff (!presetn)
      (detect_window_length == 3'h0) |-> (detect_window_log2 == 4'h7))
      else $error("Window code 0 not 128 periods");

   hold_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
      !(psel && penable && pwrite) |=>
         $stable(cfg_q) && $stable(up_gain_q) && $stable(low_gain_q))
      else $error("Register changed without write");

   // Decode and byte lane checks
   sequence wr_unmapped_s;
      psel && penable && pwrite && !mapped;
   endsequence
   unmapped_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr_unmapped_s |=> $stable(cfg_q) && $stable(up_gain_q) && $stable(low_gain_q))
      else $error("Unmapped write changed a register");

   sequence wr_cfg_hi_s;
      psel && penable && pwrite && hit_cfg && (pstrb[1:0] == 2'b10);
   endsequence
   cfg_byte_hi_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr_cfg_hi_s |=> (cfg_q[15:8] == $past(pwdata[15:8])) &&
                      (cfg_q[7:0] == $past(cfg_q[7:0])))
      else $error("Configuration byte lanes mixed");

   strb_none_a: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable && pwrite && (pstrb[1:0] == 2'b00)) |=>
         $stable(cfg_q) && $stable(up_gain_q) && $stable(low_gain_q))
      else $error("Write without lanes changed a register");

   // Read side, error response and field encoding checks
   sequence rd_setup_s;
      psel && !penable && !pwrite;
   endsequence
   sequence rd_access_s;
      psel && penable && !pwrite;
   endsequence

   low_read_a: assert property (@(posedge pclk) disable iff (!presetn)
      (rd_setup_s and hit_low) ##1 rd_access_s |->
         (prdata == {16'h0000, $past(low_gain_q)}))
      else $error("Lower gain read data wrong");

   up_read_a: assert property (@(posedge pclk) disable iff (!presetn)
      (rd_setup_s and hit_up) ##1 rd_access_s |->
         (prdata == {16'h0000, $past(up_gain_q)}))
      else $error("Upper gain read data wrong");

   cfg_read_a: assert property (@(posedge pclk) disable iff (!presetn)
      (rd_setup_s and hit_cfg) ##1 rd_access_s |->
         (prdata == {16'h0000, $past(cfg_q)}))
      else $error("Configuration read data wrong");

   err_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && !penable) ##1 (psel && penable) |-> (pslverr == !$past(mapped)))
      else $error("Error response does not match decode");

   rdata_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
      !(psel && penable && !pwrite) |-> (prdata == 32'h0000_0000))
      else $error("Read data shown outside read access");

   exceed_pow2_a: assert property (@(posedge pclk) disable iff (!presetn)
      $onehot(detect_exceed_needed) && detect_exceed_needed[detect_exceed_count])
      else $error("Exceed count not a power of two");

   chop_pow2_a: assert property (@(posedge pclk) disable iff (!presetn)
      $onehot(chop_settle_cycles) && chop_settle_cycles[{1'b0, chop_settle_delay} + 5'h01])
      else $error("Chop delay not two to code plus one");

   win_range_a: assert property (@(posedge pclk) disable iff (!presetn)
      (detect_window_log2 >= 4'h7) && (detect_window_log2 <= 4'he))
      else $error("Window length out of range");
endmodule

// ==== rtl/agcr_pkg.sv ====
// Purpose: Constants for the gain and chop configuration register bank
// Assumes: APB slave, 32-bit data, 16-bit registers in low bits
// Notes:   Offsets are register indices; byte address is four times index
package agcr_pkg;
   localparam int          AGCR_AW            = 12;
   localparam logic [11:0] AGCR_IDX_LOW_GAIN  = 12'h004;
   localparam logic [11:0] AGCR_IDX_UP_GAIN   = 12'h005;
   localparam logic [11:0] AGCR_IDX_CFG       = 12'h006;
   localparam logic [15:0] AGCR_RST_LOW_GAIN  = 16'h0000;
   localparam logic [15:0] AGCR_RST_UP_GAIN   = 16'h0000;
   localparam logic [15:0] AGCR_RST_CFG       = 16'h0600;
   localparam int          AGCR_HI_GAIN_LSB   = 4;
   localparam int          AGCR_LO_GAIN_LSB   = 0;
   localparam int          AGCR_DLY_LSB       = 9;
   localparam int          AGCR_CHOP_EN_BIT   = 8;
   localparam int          AGCR_ALLCH_BIT     = 7;
   localparam int          AGCR_NUM_LSB       = 4;
   localparam int          AGCR_LEN_LSB       = 1;
   localparam int          AGCR_DET_EN_BIT    = 0;
   localparam logic [2:0]  AGCR_LEN_BASE_LOG2 = 3'h7;
   typedef logic [2:0] agcr_gain_t;
endpackage

// ==== sim/agcr_regs_test.sv ====
// Purpose: Self-checking bench for the gain and chop/detect register bank
// Assumes: Zero-wait APB slave; byte address is four times register index
// Notes:   Random traffic from a fixed xorshift seed, with a code sweep
`timescale 1ns/1ps
module agcr_regs_test;
   import agcr_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [13:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, seed = 32'hfdbbf68c;
   logic [3:0] pstrb = 0;
   logic pready, pslverr, chop_enable, detect_all_channels, detect_enable;
   agcr_gain_t ch0_gain_code, ch1_gain_code, ch4_gain_code, ch5_gain_code;
   logic [7:0] ch0_gain_mult, ch1_gain_mult, ch4_gain_mult, ch5_gain_mult, detect_exceed_needed;
   logic [3:0] chop_settle_delay, detect_window_log2;
   logic [16:0] chop_settle_cycles;
   logic [2:0] detect_exceed_count, detect_window_length;
   logic [15:0] m [0:2];
   logic [13:0] atab [0:7] = '{14'h10, 14'h14, 14'h18, 14'h10, 14'h14, 14'h18, 14'h1c, 14'h0};
   int miscompares = 0, checks_done = 0, cyc = 0;
   agcr_regs uut (
      .pclk                 (pclk),
      .presetn              (presetn),
      .psel                 (psel),
      .penable              (penable),
      .pwrite               (pwrite),
      .paddr                (paddr),
      .pwdata               (pwdata),
      .pstrb                (pstrb),
      .prdata               (prdata),
      .pready               (pready),
      .pslverr              (pslverr),
      .ch0_gain_code        (ch0_gain_code),
      .ch1_gain_code        (ch1_gain_code),
      .ch4_gain_code        (ch4_gain_code),
      .ch5_gain_code        (ch5_gain_code),
      .ch0_gain_mult        (ch0_gain_mult),
      .ch1_gain_mult        (ch1_gain_mult),
      .ch4_gain_mult        (ch4_gain_mult),
      .ch5_gain_mult        (ch5_gain_mult),
      .chop_settle_delay    (chop_settle_delay),
      .chop_settle_cycles   (chop_settle_cycles),
      .chop_enable          (chop_enable),
      .detect_all_channels  (detect_all_channels),
      .detect_exceed_count  (detect_exceed_count),
      .detect_exceed_needed (detect_exceed_needed),
      .detect_window_length (detect_window_length),
      .detect_window_log2   (detect_window_log2),
      .detect_enable        (detect_enable)
   );
   initial forever #10 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         tally_and_finish();
      end
   end
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // Host keeps reserved bits at zero, except bits 14:12 and 10:8 of the lower gain register
   function automatic logic [15:0] rsv_clear(input logic [13:0] a, input logic [15:0] d);
      if (a == 14'h10) return d & 16'h7777;
      else if (a == 14'h14) return d & 16'h0077;
      else if (a == 14'h18) return d & 16'h1fff;
      return d;
   endfunction
   task automatic bad(input logic [31:0] g, input logic [31:0] e);
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
   endtask
   task automatic cmp_data(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) bad(g, e);
   endtask
   task automatic cmp_flag(input logic g, input logic e);
      checks_done++;
      if (g !== e) bad({31'h0, g}, {31'h0, e});
   endtask
   task automatic cmp_field(input logic [16:0] g, input logic [16:0] e);
      checks_done++;
      if (g !== e) bad({15'h0, g}, {15'h0, e});
   endtask
   task automatic apb(input logic wr, input logic [13:0] a, input logic [15:0] d,
                      input logic [3:0] s);
      logic [31:0] rd, r;
      logic er;
      int k;
      k = (a == 14'h10) ? 0 : (a == 14'h14) ? 1 : (a == 14'h18) ? 2 : 3;
      r = rnd();
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= wr;
      paddr <= a;
      pstrb <= s;
      pwdata <= {r[31:16], d};
      @(posedge pclk);
      penable <= 1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
      cmp_flag(er, k == 3);
      if (!wr) cmp_data(rd, (k == 3) ? 32'h0 : {16'h0, m[k]});
      else if (k < 3) begin
         if (s[0]) m[k][7:0] = d[7:0];
         if (s[1]) m[k][15:8] = d[15:8];
      end
   endtask
   task automatic check_fields();
      @(negedge pclk);
      cmp_field(ch0_gain_code, m[0][2:0]);
      cmp_field(ch1_gain_code, m[0][6:4]);
      cmp_field(ch4_gain_code, m[1][2:0]);
      cmp_field(ch5_gain_code, m[1][6:4]);
      cmp_field(ch0_gain_mult, 17'd1 << m[0][2:0]);
      cmp_field(ch1_gain_mult, 17'd1 << m[0][6:4]);
      cmp_field(ch4_gain_mult, 17'd1 << m[1][2:0]);
      cmp_field(ch5_gain_mult, 17'd1 << m[1][6:4]);
      cmp_field(chop_settle_delay, m[2][12:9]);
      cmp_field(chop_settle_cycles, 17'd2 << m[2][12:9]);
      cmp_field(chop_enable, m[2][8]);
      cmp_field(detect_all_channels, m[2][7]);
      cmp_field(detect_exceed_count, m[2][6:4]);
      cmp_field(detect_exceed_needed, 17'd1 << m[2][6:4]);
      cmp_field(detect_window_length, m[2][3:1]);
      cmp_field(detect_window_log2, m[2][3:1] + 17'd7);
      cmp_field(detect_enable, m[2][0]);
   endtask
   task automatic reset_and_read();
      m[0] = 16'h0000;
      m[1] = 16'h0000;
      m[2] = 16'h0600;
      check_fields();
      apb(0, 14'h10, 16'h0, 4'h0);
      apb(0, 14'h14, 16'h0, 4'h0);
      apb(0, 14'h18, 16'h0, 4'h0);
   endtask
   task automatic tally_and_finish();
      if (miscompares == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      logic [31:0] r;
      logic [2:0] c;
      repeat (3) @(posedge pclk);
      presetn <= 1;
      reset_and_read();
      for (int i = 0; i < 16; i++) begin
         r = rnd();
         c = i[2:0];
         apb(1, 14'h10, {9'h0, ~c, 1'b0, c}, 4'h3);
         apb(1, 14'h14, {9'h0, c, 1'b0, ~c}, 4'h3);
         apb(1, 14'h18, {3'h0, i[3:0], r[8:0]}, 4'h3);
         check_fields();
      end
      for (int i = 0; i < 120; i++) begin
         r = rnd();
         apb(r[3], atab[r[31:29]], rsv_clear(atab[r[31:29]], r[23:8]), r[7:4]);
         check_fields();
      end
      @(posedge pclk);
      presetn <= 0;
      repeat (2) @(posedge pclk);
      presetn <= 1;
      reset_and_read();
      tally_and_finish();
   end
endmodule
